// file: design/sbsp_pkg.sv
// Purpose: Shared constants for the synchronous burst memory port
// Assumes: Four byte lanes, each eight data bits plus one parity bit
// Notes: Widths here are defaults for the top-level parameters
package sbsp_pkg;
  localparam int ADDR_W = 19;
  localparam int BYTES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = BYTES * (LANE_W + 1);
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 32;
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic MODE_LINEAR = 1'h0;
  localparam logic MODE_RESET = 1'h1;
endpackage

// file: design/sbsp_port.sv
// Purpose: Synchronous pipelined burst memory port with write buffering
// Assumes: Pins other than output enable sampled on i_mclk; sleep and output enable also gate the output drive at once
// Notes: Writes pass through a FIFO before reaching the storage array
`timescale 1ns/1ps

// Write buffer between the pins and the storage array
module sbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sbsp_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  import sbsp_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } sbsp_fifo_s;

  sbsp_fifo_s s_q;
  sbsp_fifo_s s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction

  // Full at DEPTH entries; count is one bit wider than the pointers
  assign o_in_ready = (s_q.count != (PTR_W + 1)'(DEPTH));
  assign o_out_valid = (s_q.count != '0);
  assign o_out_data = mem_q[s_q.rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr_ptr = ptr_inc(s_q.wr_ptr);
    end
    if (pop) begin
      s_d.rd_ptr = ptr_inc(s_q.rd_ptr);
    end
    case ({push, pop})
      2'b10: s_d.count = s_q.count + (PTR_W + 1)'(1);
      2'b01: s_d.count = s_q.count - (PTR_W + 1)'(1);
      2'b11: s_d.count = s_q.count;
      default: s_d.count = s_q.count;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_q.wr_ptr <= '0;
      s_q.rd_ptr <= '0;
      s_q.count <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[s_q.wr_ptr] <= i_in_data;
    end
  end
endmodule // sbsp_fifo

// Pin-level port: decode, burst counter, storage and read register
module sbsp_port #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W,
  parameter int BYTES = sbsp_pkg::BYTES,
  parameter int FIFO_DEPTH = sbsp_pkg::FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [BYTES-1:0] i_byte_select_n,
  input wire logic i_chip_sel_first_n,
  input wire logic i_chip_sel_second,
  input wire logic i_chip_sel_third_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order,
  input wire logic [BYTES*sbsp_pkg::LANE_W-1:0] i_dq,
  input wire logic [BYTES-1:0] i_parity_io,
  output logic [BYTES*sbsp_pkg::LANE_W-1:0] o_dq,
  output logic [BYTES-1:0] o_parity_io,
  output logic o_dq_oe_n,
  output logic o_wr_ready
);
  import sbsp_pkg::*;

  localparam int DW = BYTES * (LANE_W + 1);
  localparam int FW = ADDR_W + BYTES + DW;

  typedef struct packed {
    logic sel;
    logic rd_valid;
    logic mode_taken;
    logic mode;
    logic [ADDR_W-1:0] base;
    logic [BURST_W-1:0] cnt;
    logic [DW-1:0] rd_data;
  } sbsp_port_s;

  sbsp_port_s s_q;
  sbsp_port_s s_d;
  logic [DW-1:0] mem_q [2**ADDR_W];

  logic sel_now;
  logic p_ok;
  logic c_ok;
  logic load;
  logic burst_advance_n;
  logic wr_now;
  logic rd_now;
  logic [BYTES-1:0] wmask;
  logic [BURST_W-1:0] cnt_next;
  logic [ADDR_W-1:0] cur_addr;
  logic push_valid;
  logic [FW-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [FW-1:0] pop_data;
  logic [ADDR_W-1:0] drain_addr;
  logic [DW-1:0] drain_mask;
  logic [DW-1:0] drain_data;

  // Burst low bits from start bits and step count
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic mode);
    if (mode == MODE_LINEAR) begin
      return start + cnt;
    end
    return start ^ cnt;
  endfunction

  // Bit mask over data and parity lanes for a set of enabled bytes
  function automatic logic [DW-1:0] lane_mask(input logic [BYTES-1:0] en);
    logic [DW-1:0] m;
    m = '0;
    for (int b = 0; b < BYTES; b++) begin
      m[b*LANE_W +: LANE_W] = {LANE_W{en[b]}};
      m[BYTES*LANE_W + b] = en[b];
    end
    return m;
  endfunction

  // Strobe and select decode for this edge
  always_comb begin
    sel_now = 1'b0;
    p_ok = 1'b0;
    c_ok = 1'b0;
    if (!i_chip_sel_first_n && i_chip_sel_second && !i_chip_sel_third_n) begin
      sel_now = 1'b1;
    end
    // Sleep blocks both strobes so no access starts while halted
    if (!i_sleep_request) begin
      if (!i_processor_addr_strobe_n && !i_chip_sel_first_n) begin
        p_ok = 1'b1;
      end else if (!i_controller_addr_strobe_n) begin
        c_ok = 1'b1;
      end
    end
  end

  assign load = p_ok || c_ok;

  // Advance is ignored on load edges; loads that select the device restart the counter
  always_comb begin
    burst_advance_n = 1'b0;
    if (!load && s_q.sel && !i_sleep_request) begin
      burst_advance_n = !i_burst_advance_n;
    end
  end

  // Global write overrides the byte controls
  always_comb begin
    if (!i_global_write_n) begin
      wmask = '1;
    end else if (!i_byte_write_enable_n) begin
      wmask = ~i_byte_select_n;
    end else begin
      wmask = '0;
    end
  end

  // Counter value for this edge, stepped first when advance is low
  always_comb begin
    if (burst_advance_n) begin
      cnt_next = s_q.cnt + BURST_STEP;
    end else begin
      cnt_next = s_q.cnt;
    end
  end

  // Burst steps change only the low address bits
  always_comb begin
    if (load) begin
      cur_addr = i_addr;
    end else begin
      cur_addr = s_q.base;
      cur_addr[BURST_W-1:0] = burst_low(s_q.base[BURST_W-1:0], cnt_next, s_q.mode);
    end
  end

  // Processor strobe loads ignore the write controls in their first cycle
  always_comb begin
    wr_now = 1'b0;
    rd_now = 1'b0;
    if (load) begin
      if (sel_now) begin
        wr_now = c_ok && (wmask != '0);
        rd_now = !wr_now;
      end
    end else if (s_q.sel && !i_sleep_request) begin
      wr_now = (wmask != '0);
      rd_now = !wr_now;
    end
  end

  // Next state: strap capture, address load, burst step, read capture
  always_comb begin
    s_d = s_q;
    if (!s_q.mode_taken) begin
      // Strap is taken once after reset; later changes are ignored
      s_d.mode = i_burst_order;
      s_d.mode_taken = 1'b1;
    end
    if (load) begin
      s_d.sel = sel_now;
      if (sel_now) begin
        s_d.base = i_addr;
        s_d.cnt = BURST_START;
      end
    end else begin
      s_d.cnt = cnt_next;
    end
    // Reads see only the array, so a still queued write returns old data
    if (rd_now) begin
      s_d.rd_data = mem_q[cur_addr];
    end
    // A load that leaves deselect drops its data so the pins stay off
    s_d.rd_valid = rd_now && !(load && !s_q.sel);
  end

  // A queued word holds address, lane mask, parity and data
  // A write that meets a full buffer is lost; o_wr_ready warns the master
  assign push_valid = wr_now;
  assign push_data = {cur_addr, wmask, i_parity_io, i_dq};
  assign pop_ready = !i_sleep_request;

  sbsp_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_valid),
    .o_in_ready(o_wr_ready),
    .i_in_data(push_data),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_data)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_q.sel <= 1'b0;
      s_q.rd_valid <= 1'b0;
      s_q.mode_taken <= 1'b0;
      s_q.mode <= MODE_RESET;
      s_q.base <= '0;
      s_q.cnt <= BURST_START;
      s_q.rd_data <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign drain_addr = pop_data[FW-1 -: ADDR_W];
  assign drain_mask = lane_mask(pop_data[DW +: BYTES]);
  assign drain_data = pop_data[DW-1:0];

  // Drain buffered writes into the array, lane by lane
  always_ff @(posedge i_mclk) begin
    if (pop_valid && pop_ready) begin
      mem_q[drain_addr] <= (mem_q[drain_addr] & ~drain_mask) |
                           (drain_data & drain_mask);
    end
  end

  // Sleep and output enable act at once, without waiting for an edge
  always_comb begin
    o_dq = s_q.rd_data[BYTES*LANE_W-1:0];
    o_parity_io = s_q.rd_data[DW-1 -: BYTES];
    o_dq_oe_n = 1'b1;
    if (s_q.rd_valid && !i_output_enable_n && !i_sleep_request) begin
      o_dq_oe_n = 1'b0;
    end
  end
endmodule // sbsp_port

// file: tb/sbsp_port_props.sv
// Purpose: Pin-level checks for the burst memory port
// Assumes: Pins other than output enable sampled on rising i_mclk
// Notes: Selection state is tracked from the pins
`timescale 1ns/1ps
module sbsp_port_props (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic i_chip_sel_first_n,
  input wire logic i_chip_sel_second,
  input wire logic i_chip_sel_third_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic o_dq_oe_n,
  input wire logic o_wr_ready
);
  logic pl, ld, sel, rd, sel_q;
  assign pl = !i_processor_addr_strobe_n && !i_chip_sel_first_n;
  assign ld = (pl || !i_controller_addr_strobe_n) && !i_sleep_request;
  assign sel = !i_chip_sel_first_n && i_chip_sel_second && !i_chip_sel_third_n;
  assign rd = !i_sleep_request && (pl || (i_global_write_n && i_byte_write_enable_n))
    && sel_q && (!ld || sel);
  always_ff @(posedge i_mclk) begin
    sel_q <= !i_rst_n ? 1'b0 : (ld ? sel : sel_q);
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_read;
    rd && !i_output_enable_n;
  endsequence
  sequence s_on;
    !i_output_enable_n && !i_sleep_request;
  endsequence
  a_oe_high_off: assert property (i_output_enable_n |-> o_dq_oe_n)
    else $error("pins driven with output enable high");
  a_sleep_off: assert property (i_sleep_request |-> o_dq_oe_n)
    else $error("pins driven while sleeping");
  a_sleep_hold: assert property ($past(i_sleep_request) |-> $stable(o_wr_ready))
    else $error("buffer moved while sleeping");
  a_read_drive: assert property (s_read ##1 s_on |-> !o_dq_oe_n)
    else $error("read data not driven");
  a_emerge_mute: assert property (ld && sel && !sel_q |=> o_dq_oe_n)
    else $error("driven in first cycle after deselect");
  a_deselect_off: assert property (ld && !sel |=> o_dq_oe_n)
    else $error("driven after deselecting load");
  a_proc_ignored: assert property (!sel_q && i_chip_sel_first_n && i_controller_addr_strobe_n
    |=> o_dq_oe_n)
    else $error("processor strobe taken with first select high");
  a_write_mute: assert property (ld && !pl && !i_global_write_n |=> o_dq_oe_n)
    else $error("driven after write cycle");
endmodule // sbsp_port_props
bind sbsp_port sbsp_port_props u_sbsp_port_props (.i_mclk, .i_rst_n,
  .i_processor_addr_strobe_n, .i_controller_addr_strobe_n, .i_global_write_n,
  .i_byte_write_enable_n, .i_chip_sel_first_n, .i_chip_sel_second, .i_chip_sel_third_n,
  .i_output_enable_n, .i_sleep_request, .o_dq_oe_n, .o_wr_ready);

// file: tb/sbsp_master.sv
// Purpose: Bus master model driving the memory port pins
// Assumes: Control word is selects, write, advance and strobe pins, active levels as on the pins
// Notes: Data lines show the inverse of their last value when both write pins and the processor strobe are high
`timescale 1ns/1ps
module sbsp_master (
  input wire logic i_mclk,
  output logic [7:0] o_addr,
  output logic [11:0] o_ctl,
  output logic [35:0] o_d
);
  initial begin
    o_addr = 8'h00;
    o_ctl = 12'hffd;
    o_d = 36'h0;
  end
  // One cycle, held through the sampling edge
  task automatic op(input logic [11:0] c, input logic [7:0] a, input logic [35:0] d);
    o_ctl = c;
    o_addr = a;
    o_d = (c[4] && c[3] && c[7]) ? ~o_d : d;
    @(posedge i_mclk);
    #1;
  endtask
endmodule // sbsp_master

// file: tb/test_sbsp_port.sv
// Purpose: Self-checking bench for the burst memory port
// Assumes: Narrow address for simulation
// Notes: Expected data kept in a local memory image
`timescale 1ns/1ps
module test_sbsp_port;
  localparam logic [11:0] IDLE = 12'hffd, RDC = 12'hfba, WR_ALL = 12'hfaa, WR_BYTE = 12'hab2;
  localparam logic [11:0] STEP = 12'hfdd, BOTH = 12'hf2a, PIGN = 12'hf7e;
  logic i_mclk, i_rst_n, i_output_enable_n, i_sleep_request, i_burst_order, o_dq_oe_n;
  logic o_wr_ready;
  logic [7:0] addr;
  logic [11:0] ctl;
  logic [35:0] d;
  logic [31:0] o_dq;
  logic [3:0] o_parity_io;
  logic [35:0] mem [256];
  int fails = 0;
  int cmp_count = 0;
  sbsp_master u_sbsp_master (.i_mclk, .o_addr(addr), .o_ctl(ctl), .o_d(d));
  sbsp_port #(.ADDR_W(8)) u_sbsp_port (.i_mclk, .i_rst_n, .i_addr(addr),
    .i_processor_addr_strobe_n(ctl[7]), .i_controller_addr_strobe_n(ctl[6]),
    .i_burst_advance_n(ctl[5]), .i_global_write_n(ctl[4]), .i_byte_write_enable_n(ctl[3]),
    .i_byte_select_n(ctl[11:8]), .i_chip_sel_first_n(ctl[2]), .i_chip_sel_second(ctl[1]),
    .i_chip_sel_third_n(ctl[0]), .i_output_enable_n, .i_sleep_request, .i_burst_order,
    .i_dq(d[31:0]), .i_parity_io(d[35:32]), .o_dq, .o_parity_io, .o_dq_oe_n, .o_wr_ready);
  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] b_n);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (!b_n[b]) begin
        merge[8*b +: 8] = n[8*b +: 8];
        merge[32+b] = n[32+b];
      end
    end
  endfunction
  task automatic wr(input logic [11:0] c, input logic [7:0] a, input logic [35:0] v);
    u_sbsp_master.op(c, a, v);
    mem[a] = c[4] ? merge(mem[a], v, c[11:8]) : v;
    cmp("oe_n", 36'h1, {35'h0, o_dq_oe_n});
    cmp("wr_ready", 36'h1, {35'h0, o_wr_ready});
  endtask
  task automatic rd(input logic [11:0] c, input logic [7:0] a, input logic [35:0] e);
    u_sbsp_master.op(c, a, 36'h0);
    cmp("oe_n", 36'h0, {35'h0, o_dq_oe_n});
    cmp("dq", e, {o_parity_io, o_dq});
  endtask
  task automatic off(input logic [11:0] c, input logic [7:0] a);
    u_sbsp_master.op(c, a, 36'h0);
    cmp("oe_n", 36'h1, {35'h0, o_dq_oe_n});
  endtask
  task automatic t_reset_state;
    cmp("oe_n", 36'h1, {35'h0, o_dq_oe_n});
    cmp("dq", 36'h0, {o_parity_io, o_dq});
    cmp("wr_ready", 36'h1, {35'h0, o_wr_ready});
  endtask
  task automatic t_write_read;
    for (int i = 0; i < 4; i++) begin
      wr(WR_ALL, 8'h4c + 8'(i), 36'h9_5a5a_0000 + 36'(i));
    end
    wr(WR_BYTE, 8'h4d, 36'h6_c3c3_c3c3);
    rd(12'h0ba, 8'h4e, mem[8'h4e]);
    u_sbsp_master.op(IDLE, 8'h00, 36'h0);
    rd(RDC, 8'h4d, mem[8'h4d]);
  endtask
  task automatic t_burst(input logic ord);
    logic [1:0] lo;
    rd(RDC, 8'h4d, mem[8'h4d]);
    for (int k = 1; k < 5; k++) begin
      lo = ord ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
      rd(STEP, 8'h00, mem[{6'h13, lo}]);
    end
  endtask
  task automatic t_strobes;
    rd(BOTH, 8'h4c, mem[8'h4c]);
    rd(PIGN, 8'h4f, mem[8'h4c]);
    u_sbsp_master.op(IDLE, 8'h00, 36'h0);
    rd(RDC, 8'h4c, mem[8'h4c]);
  endtask
  task automatic t_select;
    for (int s = 0; s < 8; s++) begin
      if (s != 2) begin
        off({4'hf, 5'h17, 3'(s)}, 8'h4c);
        off(PIGN, 8'h4c);
        off(RDC, 8'h4e);
        rd(RDC, 8'h4e, mem[8'h4e]);
      end
    end
  endtask
  task automatic t_oe_sleep;
    i_output_enable_n = 1'b1;
    off(RDC, 8'h4f);
    i_output_enable_n = 1'b0;
    rd(IDLE, 8'h00, mem[8'h4f]);
    i_sleep_request = 1'b1;
    off(RDC, 8'h4c);
    i_sleep_request = 1'b0;
    rd(RDC, 8'h4c, mem[8'h4c]);
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    fails++;
    end_of_test;
  end
  initial begin
    i_rst_n = 1'b0;
    i_output_enable_n = 1'b0;
    i_sleep_request = 1'b0;
    i_burst_order = 1'b0;
    repeat (16) @(posedge i_mclk);
    #1;
    t_reset_state;
    for (int r = 0; r < 2; r++) begin
      i_rst_n = 1'b1;
      u_sbsp_master.op(IDLE, 8'h00, 36'h0);
      t_write_read;
      t_burst(i_burst_order);
      t_strobes;
      t_select;
      t_oe_sleep;
      i_rst_n = 1'b0;
      i_burst_order = 1'b1;
      u_sbsp_master.op(IDLE, 8'h00, 36'h0);
      t_reset_state;
    end
    end_of_test;
  end
endmodule // test_sbsp_port
